// >>> logic/sascs_pkg.sv
// Shared constants, pin indices and state encoding of the conversion sequencer.
package sascs_pkg;
    // Counter width, enough for the longest phase.
    localparam int TIM_W = 11;
    // Phase lengths in converter clock periods.
    localparam logic [10:0] ACQ_CLKS = 11'h007;
    localparam logic [10:0] WR_CONV_CLKS = 11'h01b;
    localparam logic [10:0] SH_CONV_CLKS = 11'h022;
    localparam logic [10:0] AZ_CLKS = 11'h01a;
    localparam logic [10:0] CAL_CLKS = 11'h577;
    // Approximation cycles left after the internal acquisition window.
    localparam logic [10:0] WR_SAR_CLKS = WR_CONV_CLKS - ACQ_CLKS;
    // Counter value at which the first trial code is loaded.
    localparam logic [10:0] SAR_PRE = 11'h00d;
    localparam logic [10:0] CNT_RST = 11'h000;
    // Result layout.
    localparam int RES_W = 13;
    localparam int SIGN_BIT = 12;
    localparam int MSB_BIT = 11;
    localparam logic [12:0] RES_RST = 13'h0000;
    // Positions of the synchronised control pins.
    localparam int PIN_N = 6;
    localparam int IX_CS = 0;
    localparam int IX_RD = 1;
    localparam int IX_WR = 2;
    localparam int IX_SH = 3;
    localparam int IX_CAL = 4;
    localparam int IX_AZ = 5;
    // All control pins are idle high.
    localparam logic [5:0] PIN_RST = 6'h3f;
    localparam logic EOC_RST = 1'b1;
    localparam logic INT_N_RST = 1'b1;
    localparam logic OE_N_RST = 1'b1;
    localparam logic PTR_RST = 1'b0;
    localparam logic [7:0] BYTE_RST = 8'h00;
    // Sequencer states.
    typedef enum logic [5:0] {
        SASCS_IDLE = 6'h01,
        SASCS_ACQ = 6'h02,
        SASCS_SHACQ = 6'h04,
        SASCS_AZERO = 6'h08,
        SASCS_SAR = 6'h10,
        SASCS_CAL = 6'h20
    } sascs_state_t;
endpackage : sascs_pkg

// >>> logic/sascs_tim_if.sv
// Interface between the sequencer and its phase timer.
`timescale 1ns/100ps
interface sascs_tim_if;
    logic load;
    logic [10:0] val;
    logic [10:0] cnt;
    logic zero;
    modport ctl (output load, output val, input cnt, input zero);
    modport tmr (input load, input val, output cnt, output zero);
endinterface : sascs_tim_if

// >>> logic/sascs_timer.sv
// Down counter that times each sequencer phase except SASCS_SHACQ, which the hold strobe ends.
`timescale 1ns/100ps
module sascs_timer (
    input wire logic mclk,
    input wire logic rst,
    sascs_tim_if.tmr tif
);
    logic [10:0] cnt_q;

    // Loading wins over counting; the count rests at zero.
    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_q <= sascs_pkg::CNT_RST;
        end else if (tif.load) begin
            cnt_q <= tif.val;
        end else if (cnt_q != sascs_pkg::CNT_RST) begin
            cnt_q <= cnt_q - 11'h001;
        end
    end

    // The phase ends in the cycle where the count is zero.
    assign tif.cnt = cnt_q;
    assign tif.zero = (cnt_q == sascs_pkg::CNT_RST);
endmodule : sascs_timer

// >>> logic/sascs_top.sv
// Conversion sequencer of a 12-bit plus sign successive-approximation converter.
`timescale 1ns/100ps
module sascs_top (
    input wire logic mclk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic sh_n,
    input wire logic cal_n,
    input wire logic zero_correct_req_n,
    input wire logic cmp_above,
    output logic [7:0] result_byte_bus,
    output logic result_byte_oe_n,
    output logic eoc,
    output logic int_n,
    output logic [12:0] dac_code
);
    sascs_tim_if tif ();

    sascs_timer u_timer (
        .mclk(mclk),
        .rst(rst),
        .tif(tif)
    );

    // Load value for a phase that lasts n cycles.
    function automatic logic [10:0] tim_len(input logic [10:0] n);
        tim_len = n - 11'h001;
    endfunction : tim_len

    // One-hot mask of a result bit.
    function automatic logic [12:0] sar_bit(input logic [3:0] i);
        sar_bit = 13'h0001 << i;
    endfunction : sar_bit

    logic [5:0] pin_meta_q;
    logic [5:0] pin_s_q;
    logic [5:0] pin_p_q;
    sascs_pkg::sascs_state_t st_q;
    sascs_pkg::sascs_state_t st_d;
    logic from_wr_q;
    logic [12:0] dac_q;
    logic [12:0] res_q;
    logic [12:0] resolved;
    logic [7:0] byte_q;
    logic oe_n_q;
    logic ptr_lo_q;
    logic eoc_q;
    logic int_n_q;
    logic [10:0] cal_len_q;
    logic sel;
    logic rd_fall;
    logic rd_rise;
    logic wr_fall;
    logic wr_rise;
    logic sh_fall;
    logic sh_rise;
    logic cal_fall;
    logic go_hold;
    logic started;
    logic conv_done;

    // Two-stage synchroniser for all control pins, plus an edge history stage.
    always_ff @(posedge mclk) begin
        if (rst) begin
            pin_meta_q <= sascs_pkg::PIN_RST;
            pin_s_q <= sascs_pkg::PIN_RST;
            pin_p_q <= sascs_pkg::PIN_RST;
        end else begin
            pin_meta_q <= {zero_correct_req_n, cal_n, sh_n, wr_n, rd_n, cs_n};
            pin_s_q <= pin_meta_q;
            pin_p_q <= pin_s_q;
        end
    end

    // Read, write and hold strobe edges only count while the device is selected; the calibrate edge always counts.
    assign sel = !pin_s_q[sascs_pkg::IX_CS];
    assign rd_fall = sel && pin_p_q[sascs_pkg::IX_RD] && !pin_s_q[sascs_pkg::IX_RD];
    assign rd_rise = sel && !pin_p_q[sascs_pkg::IX_RD] && pin_s_q[sascs_pkg::IX_RD];
    assign wr_fall = sel && pin_p_q[sascs_pkg::IX_WR] && !pin_s_q[sascs_pkg::IX_WR];
    assign wr_rise = sel && !pin_p_q[sascs_pkg::IX_WR] && pin_s_q[sascs_pkg::IX_WR];
    assign sh_fall = sel && pin_p_q[sascs_pkg::IX_SH] && !pin_s_q[sascs_pkg::IX_SH];
    assign sh_rise = sel && !pin_p_q[sascs_pkg::IX_SH] && pin_s_q[sascs_pkg::IX_SH];
    assign cal_fall = pin_p_q[sascs_pkg::IX_CAL] && !pin_s_q[sascs_pkg::IX_CAL];

    // Next state and timer loads; calibration overrides any phase.
    always_comb begin
        st_d = st_q;
        tif.load = 1'b0;
        tif.val = sascs_pkg::CNT_RST;
        go_hold = 1'b0;
        if (cal_fall) begin
            st_d = sascs_pkg::SASCS_CAL;
            tif.load = 1'b1;
            tif.val = tim_len(sascs_pkg::CAL_CLKS);
        end else begin
            case (st_q)
                sascs_pkg::SASCS_IDLE: begin
                    if (wr_rise) begin
                        st_d = sascs_pkg::SASCS_ACQ;
                        tif.load = 1'b1;
                        tif.val = tim_len(sascs_pkg::ACQ_CLKS);
                    end else if (sh_fall) begin
                        st_d = sascs_pkg::SASCS_SHACQ;
                    end
                end
                sascs_pkg::SASCS_ACQ: begin
                    go_hold = tif.zero;
                end
                sascs_pkg::SASCS_SHACQ: begin
                    go_hold = sh_rise;
                end
                sascs_pkg::SASCS_AZERO: begin
                    if (tif.zero) begin
                        st_d = sascs_pkg::SASCS_SAR;
                        tif.load = 1'b1;
                        tif.val = from_wr_q ? tim_len(sascs_pkg::WR_SAR_CLKS)
                                            : tim_len(sascs_pkg::SH_CONV_CLKS);
                    end
                end
                sascs_pkg::SASCS_SAR: begin
                    if (tif.zero) begin
                        st_d = sascs_pkg::SASCS_IDLE;
                    end
                end
                sascs_pkg::SASCS_CAL: begin
                    if (tif.zero) begin
                        st_d = sascs_pkg::SASCS_IDLE;
                    end
                end
                default: begin
                    st_d = sascs_pkg::SASCS_IDLE;
                end
            endcase
            // At the hold point an optional zeroing phase runs first.
            if (go_hold) begin
                tif.load = 1'b1;
                if (!pin_s_q[sascs_pkg::IX_AZ]) begin
                    st_d = sascs_pkg::SASCS_AZERO;
                    tif.val = tim_len(sascs_pkg::AZ_CLKS);
                end else begin
                    st_d = sascs_pkg::SASCS_SAR;
                    tif.val = (st_q == sascs_pkg::SASCS_ACQ)
                              ? tim_len(sascs_pkg::WR_SAR_CLKS)
                              : tim_len(sascs_pkg::SH_CONV_CLKS);
                end
            end
        end
    end

    // State register and the start method of the running conversion.
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_q <= sascs_pkg::SASCS_IDLE;
            from_wr_q <= 1'b0;
        end else begin
            st_q <= st_d;
            if (st_q == sascs_pkg::SASCS_IDLE) begin
                from_wr_q <= wr_rise;
            end
        end
    end

    // Comparator decision on the bit under trial.
    always_comb begin
        resolved = cmp_above ? dac_q : (dac_q & ~sar_bit(tif.cnt[3:0]));
    end

    // Successive approximation, one bit per cycle over the last 13 cycles.
    always_ff @(posedge mclk) begin
        if (rst) begin
            dac_q <= sascs_pkg::RES_RST;
            res_q <= sascs_pkg::RES_RST;
        end else if (st_q == sascs_pkg::SASCS_SAR) begin
            if (tif.cnt == sascs_pkg::SAR_PRE) begin
                dac_q <= sar_bit(4'(sascs_pkg::SIGN_BIT));
            end else if (tif.cnt < sascs_pkg::SAR_PRE) begin
                if (!tif.zero) begin
                    dac_q <= resolved | sar_bit(tif.cnt[3:0] - 4'h1);
                end else if (!cal_fall) begin
                    // Offset binary becomes two's complement by flipping the sign.
                    res_q <= {~resolved[sascs_pkg::SIGN_BIT],
                              resolved[sascs_pkg::MSB_BIT:0]};
                    dac_q <= sascs_pkg::RES_RST;
                end
            end
        end else begin
            dac_q <= sascs_pkg::RES_RST;
        end
    end

    assign started = wr_rise || go_hold || cal_fall;
    assign conv_done = (st_q == sascs_pkg::SASCS_SAR) && tif.zero && !cal_fall;

    // Done output is low during the zeroing, approximation and calibration phases.
    always_ff @(posedge mclk) begin
        if (rst) begin
            eoc_q <= sascs_pkg::EOC_RST;
        end else begin
            eoc_q <= !(st_d == sascs_pkg::SASCS_AZERO || st_d == sascs_pkg::SASCS_SAR
                       || st_d == sascs_pkg::SASCS_CAL);
        end
    end

    // Interrupt falls on completion; a completion in the same cycle beats a release.
    always_ff @(posedge mclk) begin
        if (rst) begin
            int_n_q <= sascs_pkg::INT_N_RST;
        end else if (conv_done) begin
            int_n_q <= 1'b0;
        end else if (rd_fall || wr_fall || started) begin
            int_n_q <= 1'b1;
        end
    end

    // Byte pointer: high byte first after every conversion, toggled per read.
    always_ff @(posedge mclk) begin
        if (rst) begin
            ptr_lo_q <= sascs_pkg::PTR_RST;
        end else if (conv_done) begin
            ptr_lo_q <= 1'b0;
        end else if (rd_rise) begin
            ptr_lo_q <= !ptr_lo_q;
        end
    end

    // Output drivers follow the selected read strobe level.
    always_ff @(posedge mclk) begin
        if (rst) begin
            byte_q <= sascs_pkg::BYTE_RST;
            oe_n_q <= sascs_pkg::OE_N_RST;
        end else begin
            oe_n_q <= !(sel && !pin_s_q[sascs_pkg::IX_RD]);
            byte_q <= ptr_lo_q ? res_q[7:0]
                               : {{3{res_q[sascs_pkg::SIGN_BIT]}}, res_q[12:8]};
        end
    end

    // Length of the current calibration, watched by a check below.
    always_ff @(posedge mclk) begin
        if (rst || cal_fall) begin
            cal_len_q <= sascs_pkg::CNT_RST;
        end else if (st_q == sascs_pkg::SASCS_CAL) begin
            cal_len_q <= cal_len_q + 11'h001;
        end
    end

    assign result_byte_bus = byte_q;
    assign result_byte_oe_n = oe_n_q;
    assign eoc = eoc_q;
    assign int_n = int_n_q;
    assign dac_code = dac_q;

    property p_wr_time;
        @(posedge mclk) disable iff (rst)
        ($rose(st_q == sascs_pkg::SASCS_ACQ) ##7 (st_q == sascs_pkg::SASCS_SAR))
        |-> ##20 ((!int_n_q && eoc_q) || st_q == sascs_pkg::SASCS_CAL);
    endproperty
    a_wr_time: assert property (p_wr_time)
        else $error("write-started conversion did not end after 27 clocks");

    property p_sh_time;
        @(posedge mclk) disable iff (rst)
        ($rose(st_q == sascs_pkg::SASCS_SAR) && $past(st_q) == sascs_pkg::SASCS_SHACQ)
        |-> ##34 ((!int_n_q && eoc_q) || st_q == sascs_pkg::SASCS_CAL);
    endproperty
    a_sh_time: assert property (p_sh_time)
        else $error("hold-started conversion did not end after 34 clocks");

    property p_acq_len;
        @(posedge mclk) disable iff (rst)
        ($rose(st_q == sascs_pkg::SASCS_ACQ) && !cal_fall)
        |-> (st_q == sascs_pkg::SASCS_ACQ)[*7] ##1 (st_q != sascs_pkg::SASCS_ACQ);
    endproperty
    a_acq_len: assert property (p_acq_len)
        else $error("internal acquisition window is not 7 clocks");

    property p_eoc_busy;
        @(posedge mclk) disable iff (rst)
        (st_q == sascs_pkg::SASCS_SAR || st_q == sascs_pkg::SASCS_AZERO) |-> !eoc_q;
    endproperty
    a_eoc_busy: assert property (p_eoc_busy)
        else $error("done output high during a conversion");

    property p_int_release;
        @(posedge mclk) disable iff (rst)
        ((rd_fall || wr_fall) && !conv_done) |=> int_n_q;
    endproperty
    a_int_release: assert property (p_int_release)
        else $error("interrupt not released by a strobe");

    property p_drive;
        @(posedge mclk) disable iff (rst)
        (sel && !pin_s_q[sascs_pkg::IX_RD])
        |=> !oe_n_q ##1 (oe_n_q || !pin_p_q[sascs_pkg::IX_RD]);
    endproperty
    a_drive: assert property (p_drive)
        else $error("byte outputs do not follow the read strobe");

    property p_cal_len;
        @(posedge mclk) disable iff (rst)
        ($fell(st_q == sascs_pkg::SASCS_CAL) && !cal_fall)
        |-> (cal_len_q == sascs_pkg::CAL_CLKS) && eoc_q && !$past(eoc_q);
    endproperty
    a_cal_len: assert property (p_cal_len)
        else $error("calibration did not last 1399 clocks");

    property p_zero_len;
        @(posedge mclk) disable iff (rst)
        ($rose(st_q == sascs_pkg::SASCS_AZERO) && !cal_fall)
        |-> ##26 (st_q == sascs_pkg::SASCS_SAR || st_q == sascs_pkg::SASCS_CAL);
    endproperty
    a_zero_len: assert property (p_zero_len)
        else $error("zeroing phase is not 26 clocks");

    property p_done_int;
        @(posedge mclk) disable iff (rst)
        conv_done |=> (!int_n_q && eoc_q && !ptr_lo_q);
    endproperty
    a_done_int: assert property (p_done_int)
        else $error("conversion end did not raise the interrupt");

    property p_high_first;
        @(posedge mclk) disable iff (rst)
        (!oe_n_q && !ptr_lo_q && $stable(res_q))
        |-> (byte_q == {{3{res_q[sascs_pkg::SIGN_BIT]}}, res_q[12:8]});
    endproperty
    a_high_first: assert property (p_high_first)
        else $error("high byte is not the sign-extended upper result");

    property p_deselect;
        @(posedge mclk) disable iff (rst)
        (!sel && st_q == sascs_pkg::SASCS_IDLE && !cal_fall) |=> oe_n_q
        && (st_q == sascs_pkg::SASCS_IDLE);
    endproperty
    a_deselect: assert property (p_deselect)
        else $error("deselected device reacted to a strobe");
endmodule : sascs_top

// >>> verif/sascs_host_model.sv
// Host bus model driving the strobes, with a comparator stand-in for the input.
`timescale 1ns/100ps
module sascs_host_model (
    input wire logic mclk,
    input wire logic [7:0] result_byte_bus,
    input wire logic result_byte_oe_n,
    input wire logic [12:0] dac_code,
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic sh_n,
    output logic cal_n,
    output logic zero_correct_req_n,
    output logic cmp_above
);
    logic [12:0] vin;
    // The input counts as above the trial when its code is not below it.
    assign cmp_above = (vin >= dac_code);
    // All strobes rest high, device deselected.
    initial begin
        {cs_n, rd_n, wr_n, sh_n, cal_n, zero_correct_req_n} = 6'h3f;
        vin = 13'h0000;
    end
    // Selects the device and pulses one start strobe; returns at its rise.
    task automatic start(input bit use_sh, input bit zero);
        @(posedge mclk);
        cs_n <= 1'b0;
        zero_correct_req_n <= ~zero;
        if (use_sh) sh_n <= 1'b0;
        else wr_n <= 1'b0;
        repeat (use_sh ? 80 : 4) @(posedge mclk);
        wr_n <= 1'b1;
        sh_n <= 1'b1;
    endtask : start
    // One byte read; rd_n is held low until the outputs are seen enabled.
    task automatic read_byte(output logic [7:0] b, output int w_on, output int w_off);
        w_on = 0;
        w_off = 0;
        @(posedge mclk);
        rd_n <= 1'b0;
        do begin
            @(posedge mclk);
            w_on++;
        end while (result_byte_oe_n !== 1'b0 && w_on < 20);
        b = result_byte_bus;
        rd_n <= 1'b1;
        do begin
            @(posedge mclk);
            w_off++;
        end while (result_byte_oe_n !== 1'b1 && w_off < 20);
        repeat (2) @(posedge mclk);
    endtask : read_byte
    // Low pulse on the calibrate pin with the other strobes idle.
    task automatic calibrate();
        @(posedge mclk);
        cal_n <= 1'b0;
        repeat (4) @(posedge mclk);
        cal_n <= 1'b1;
    endtask : calibrate
    // Read, write and hold strobes pulsed while the device is deselected.
    task automatic deselected();
        @(posedge mclk);
        cs_n <= 1'b1;
        @(posedge mclk);
        {rd_n, wr_n, sh_n} <= 3'h0;
        repeat (6) @(posedge mclk);
        {rd_n, wr_n, sh_n} <= 3'h7;
        repeat (6) @(posedge mclk);
        cs_n <= 1'b0;
    endtask : deselected
endmodule : sascs_host_model

// >>> verif/test_sascs_top.sv
// Self-checking bench for the conversion sequencer.
`timescale 1ns/100ps
module test_sascs_top;
    localparam int LIMIT = 20000;
    localparam logic [12:0] CORNER [4] = '{13'h0000, 13'h1fff, 13'h1000, 13'h0fff};
    logic mclk;
    logic rst;
    logic cs_n, rd_n, wr_n, sh_n, cal_n, zero_correct_req_n, cmp_above;
    logic [7:0] bus;
    logic oe_n, eoc, int_n;
    logic [12:0] dac_code;
    int bad_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int run_low = 0;
    int last_low = 0;

    sascs_top dut (.mclk(mclk), .rst(rst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
        .sh_n(sh_n), .cal_n(cal_n), .zero_correct_req_n(zero_correct_req_n),
        .cmp_above(cmp_above), .result_byte_bus(bus), .result_byte_oe_n(oe_n),
        .eoc(eoc), .int_n(int_n), .dac_code(dac_code));
    sascs_host_model host (.mclk(mclk), .result_byte_bus(bus), .result_byte_oe_n(oe_n),
        .dac_code(dac_code), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .sh_n(sh_n),
        .cal_n(cal_n), .zero_correct_req_n(zero_correct_req_n), .cmp_above(cmp_above));

    // Free-running converter clock.
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // Measures each stretch of done held low, and cuts a hang short.
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (eoc === 1'b0) run_low <= run_low + 1;
        else if (run_low != 0) begin
            last_low <= run_low;
            run_low <= 0;
        end
        if (cyc == LIMIT) begin
            bad_count++;
            give_verdict();
        end
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict

    // Compares one value and reports a difference.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // High and low byte expected for an offset-binary input code.
    function automatic logic [15:0] exp_bytes(input logic [12:0] v);
        logic [12:0] r;
        r = {~v[12], v[11:0]};
        return {{3{r[12]}}, r[12:8], r[7:0]};
    endfunction : exp_bytes

    // One conversion with its hold point, length and completion checked.
    task automatic run_conv(input logic [12:0] v, input bit use_sh, input bit zero);
        int n;
        int lim;
        logic held;
        lim = (use_sh ? 34 : 27) + (zero ? 26 : 0);
        host.vin <= v;
        host.start(use_sh, zero);
        n = 0;
        while (eoc !== 1'b0 && n < 200) begin
            @(posedge mclk);
            n++;
        end
        if (use_sh) check(n >= 1 && n <= 6, 1'b1);
        else check(n >= 6 && n <= 12, 1'b1);
        check(int_n, 1'b1);
        held = 1'b1;
        while (int_n !== 1'b0 && n < 200) begin
            @(posedge mclk);
            n++;
            if (int_n !== 1'b0 && eoc !== 1'b0) held = 1'b0;
        end
        check(held, 1'b1);
        check(eoc, 1'b1);
        if (use_sh) check(n >= lim && n <= lim + 5, 1'b1);
        else check(n >= lim && n <= lim + 5, 1'b1);
        if (zero) check(n >= lim && n <= lim + 5, 1'b1);
        @(posedge mclk);
        if (!use_sh) check(16'(last_low), 16'(lim - 7));
    endtask : run_conv

    // Reads both bytes and checks enable timing, release and content.
    task automatic read_pair(input logic [12:0] v);
        logic [7:0] hb;
        logic [7:0] lb;
        int a;
        int b;
        host.read_byte(hb, a, b);
        check(int_n, 1'b1);
        check(a <= 6 && b <= 6, 1'b1);
        host.read_byte(lb, a, b);
        check({hb, lb}, exp_bytes(v));
    endtask : read_pair

    // Waits for done to return high, bounded.
    task automatic wait_done();
        int n;
        n = 0;
        while (eoc !== 1'b1 && n < 2000) begin
            @(posedge mclk);
            n++;
        end
        @(posedge mclk);
    endtask : wait_done

    // Main sequence.
    initial begin
        logic [12:0] v;
        bit s;
        bit z;
        int i;
        int n;
        rst = 1'b1;
        void'($urandom(29504));
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        check({eoc, int_n, oe_n}, 3'h7);
        for (i = 0; i < 14; i++) begin
            v = (i < 4) ? CORNER[i] : 13'($urandom);
            s = (i < 4) ? i[0] : 1'($urandom);
            z = (i < 4) ? i[1] : 1'($urandom);
            run_conv(v, s, z);
            if (i < 4 || $urandom % 2 == 0) read_pair(v);
        end
        run_conv(13'h0abc, 1'b0, 1'b0);
        n = 0;
        fork
            host.deselected();
            repeat (40) begin
                @(posedge mclk);
                if (eoc !== 1'b1 || oe_n !== 1'b1) n++;
            end
        join
        check(16'(n), 16'h0000);
        check(int_n, 1'b0);
        read_pair(13'h0abc);
        run_conv(13'h0555, 1'b1, 1'b0);
        host.calibrate();
        wait_done();
        check(16'(last_low), 16'h0577);
        check(int_n, 1'b1);
        host.start(1'b0, 1'b0);
        repeat (20) @(posedge mclk);
        host.calibrate();
        wait_done();
        repeat (40) @(posedge mclk);
        check(int_n, 1'b1);
        check(eoc, 1'b1);
        give_verdict();
    end
endmodule : test_sascs_top
